/* File: logic/alb_exec.sv */
// Execute stage for scaled adds, constant add, unsigned add, dual add, AND and branches
`timescale 1ns/1ns
module alb_exec (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_n_i,
  input  wire alb_pkg::alb_instr_t     instr_a_i,
  input  wire alb_pkg::alb_instr_t     instr_b_i,
  input  wire logic [alb_pkg::XLEN-1:0] packet_addr_i,
  output alb_pkg::alb_wb_t             wb_a_o,
  output alb_pkg::alb_wb_t             wb_b_o,
  output logic [alb_pkg::XLEN-1:0]     program_fetch_counter_o,
  output logic                         redirect_o,
  output logic                         int_block_o,
  output logic                         illegal_o
);
  import alb_pkg::*;

  alb_wb_t          wb_a, wb_b, next_wb_a, next_wb_b;
  logic [XLEN-1:0]  program_fetch_counter, next_pfc, tgt, next_tgt;
  logic             redirect, next_redirect, illegal, next_illegal;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic             pend, next_pend;
  logic             ill_a, ill_b, br_a, br_b;
  logic [XLEN-1:0]  tgt_a, tgt_b;

  function automatic alb_wb_t exec_one(input alb_instr_t in, output logic ill,
                                       output logic br, output logic [XLEN-1:0] t);
    alb_wb_t          w;
    logic [XLEN-1:0]  off, k5s, k5u, sum;
    int               sh;
    logic             circ;
    logic [LLEN-1:0]  a40, b40;
    w = '0;
    ill = 1'b0;
    br = 1'b0;
    t = '0;
    off = '0;
    sh = SH_BYTE;
    k5s = {{(XLEN-5){in.cst5[4]}}, in.cst5};
    k5u = {{(XLEN-5){1'b0}}, in.cst5};
    w.side_b = in.side_b;
    w.dst = in.dst;
    circ = in.circ_en && (in.src2_idx >= CIRC_LO) && (in.src2_idx <= CIRC_HI);
    if (in.valid && in.cond_true) begin
      unique case (in.unit)
        ALB_UNIT_D: begin
          w.we = 1'b1;
          unique case (in.opfield[OP6_W-1:0])
            OP_D_BYTE_SCALED_ADDRESS_ADD_R: begin off = in.src1; sh = SH_BYTE; end
            OP_D_BYTE_SCALED_ADDRESS_ADD_C: begin off = k5u; sh = SH_BYTE; end
            OP_D_HALFWORD_SCALED_ADDRESS_ADD_R: begin off = in.src1; sh = SH_HALF; end
            OP_D_HALFWORD_SCALED_ADDRESS_ADD_C: begin off = k5u; sh = SH_HALF; end
            OP_D_WORD_SCALED_ADDRESS_ADD_R: begin off = in.src1; sh = SH_WORD; end
            OP_D_WORD_SCALED_ADDRESS_ADD_C: begin off = k5u; sh = SH_WORD; end
            default: begin w.we = 1'b0; ill = 1'b1; end
          endcase
          sum = in.src2 + (off << sh);
          w.data = {{(LLEN-XLEN){1'b0}}, circ ? in.circ_sum : sum};
        end
        ALB_UNIT_L: begin
          w.we = 1'b1;
          a40 = {{(LLEN-XLEN){1'b0}}, in.src1};
          unique case (in.opfield)
            OP_L_UNSIGNED_WIDENING_ADD_UU: begin
              b40 = {{(LLEN-XLEN){1'b0}}, in.src2};
              w.wide = 1'b1;
              w.data = a40 + b40;
            end
            OP_L_UNSIGNED_WIDENING_ADD_UL: begin
              b40 = {in.src2_hi, in.src2};
              w.wide = 1'b1;
              w.data = a40 + b40;
            end
            OP_L_AND_R: w.data = {{(LLEN-XLEN){1'b0}}, in.src1 & in.src2};
            OP_L_AND_C: w.data = {{(LLEN-XLEN){1'b0}}, k5s & in.src2};
            default: begin w.we = 1'b0; ill = 1'b1; end
          endcase
        end
        ALB_UNIT_S: begin
          w.we = 1'b1;
          unique case (in.opfield[OP6_W-1:0])
            OP_S_AND_R: w.data = {{(LLEN-XLEN){1'b0}}, in.src1 & in.src2};
            OP_S_AND_C: w.data = {{(LLEN-XLEN){1'b0}}, k5s & in.src2};
            default: begin w.we = 1'b0; ill = 1'b1; end
          endcase
        end
        ALB_UNIT_SK: begin
          w.we = 1'b1;
          w.data = {{(LLEN-XLEN){1'b0}},
                    in.src2 + {{(XLEN-16){in.signed_sixteen_bit_constant[15]}}, in.signed_sixteen_bit_constant}};
        end
        ALB_UNIT_SADD2: begin
          w.we = 1'b1;
          w.data = {{(LLEN-XLEN){1'b0}},
                    16'(in.src1[31:16] + in.src2[31:16]),
                    16'(in.src1[15:0] + in.src2[15:0])};
        end
        ALB_UNIT_BDISP: begin
          br = 1'b1;
          t = packet_addr_i + ({{(XLEN-21){in.branch_displacement_constant[20]}}, in.branch_displacement_constant} << SH_DISP);
        end
        ALB_UNIT_BREG: begin
          if (in.side_b) begin
            br = 1'b1;
            t = in.src2;
          end else begin
            ill = 1'b1;
          end
        end
        default: ill = 1'b1;
      endcase
    end
    return w;
  endfunction : exec_one

  always_comb begin
    next_wb_a = exec_one(instr_a_i, ill_a, br_a, tgt_a);
    next_wb_b = exec_one(instr_b_i, ill_b, br_b, tgt_b);
    next_illegal = ill_a | ill_b | (br_a & br_b);
    next_pfc = program_fetch_counter;
    next_redirect = 1'b0;
    next_tgt = tgt;
    next_pend = pend;
    next_cnt = cnt;
    if (pend) begin
      if (cnt == CNT_W'(1)) begin
        next_pfc = tgt;
        next_redirect = 1'b1;
        next_pend = 1'b0;
        next_cnt = '0;
      end else begin
        next_cnt = cnt - CNT_W'(1);
      end
    end
    // Only one true branch may start; pick whichever fired
    if ((instr_a_i.valid && (instr_a_i.unit == ALB_UNIT_BDISP ||
         instr_a_i.unit == ALB_UNIT_BREG)) ||
        (instr_b_i.valid && (instr_b_i.unit == ALB_UNIT_BDISP ||
         instr_b_i.unit == ALB_UNIT_BREG))) begin
      if (br_a ^ br_b) begin
        next_tgt = br_a ? tgt_a : tgt_b;
        next_pend = 1'b1;
        next_cnt = CNT_W'(DELAY_SLOTS);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_a <= '0;
      wb_b <= '0;
      program_fetch_counter <= PFC_RST;
      tgt <= PFC_RST;
      redirect <= 1'b0;
      illegal <= 1'b0;
      pend <= 1'b0;
      cnt <= '0;
    end else begin
      wb_a <= next_wb_a;
      wb_b <= next_wb_b;
      program_fetch_counter <= next_pfc;
      tgt <= next_tgt;
      redirect <= next_redirect;
      illegal <= next_illegal;
      pend <= next_pend;
      cnt <= next_cnt;
    end
  end

  assign wb_a_o = wb_a;
  assign wb_b_o = wb_b;
  assign program_fetch_counter_o = program_fetch_counter;
  assign redirect_o = redirect;
  assign illegal_o = illegal;
  assign int_block_o = pend;

endmodule : alb_exec

/* File: logic/alb_pkg.sv */
// Package for the add, logic and branch execute block
package alb_pkg;

  localparam int XLEN      = 32;
  localparam int LLEN      = 40;
  localparam int RIDX_W    = 5;
  localparam int OP6_W     = 6;
  localparam int OP7_W     = 7;
  localparam int DELAY_SLOTS = 5;
  localparam int CNT_W     = 3;

  // Data unit opfields
  localparam logic [5:0] OP_D_BYTE_SCALED_ADDRESS_ADD_R = 6'h30;
  localparam logic [5:0] OP_D_BYTE_SCALED_ADDRESS_ADD_C = 6'h32;
  localparam logic [5:0] OP_D_HALFWORD_SCALED_ADDRESS_ADD_R = 6'h34;
  localparam logic [5:0] OP_D_HALFWORD_SCALED_ADDRESS_ADD_C = 6'h36;
  localparam logic [5:0] OP_D_WORD_SCALED_ADDRESS_ADD_R = 6'h38;
  localparam logic [5:0] OP_D_WORD_SCALED_ADDRESS_ADD_C = 6'h3A;
  // L unit opfields
  localparam logic [6:0] OP_L_UNSIGNED_WIDENING_ADD_UU = 7'h2B;
  localparam logic [6:0] OP_L_UNSIGNED_WIDENING_ADD_UL = 7'h29;
  localparam logic [6:0] OP_L_AND_R   = 7'h7B;
  localparam logic [6:0] OP_L_AND_C   = 7'h7A;
  // S unit opfields
  localparam logic [5:0] OP_S_AND_R   = 6'h1F;
  localparam logic [5:0] OP_S_AND_C   = 6'h1E;

  // Shift amounts for scaled address adds and branch displacement
  localparam int SH_BYTE = 0;
  localparam int SH_HALF = 1;
  localparam int SH_WORD = 2;
  localparam int SH_DISP = 2;

  // Circular-capable register indices 4..7
  localparam logic [4:0] CIRC_LO = 5'h04;
  localparam logic [4:0] CIRC_HI = 5'h07;

  localparam logic [XLEN-1:0] PFC_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    ALB_UNIT_L, ALB_UNIT_S, ALB_UNIT_D, ALB_UNIT_SK, ALB_UNIT_SADD2,
    ALB_UNIT_BDISP, ALB_UNIT_BREG
  } alb_unit_t;

  // One decoded instruction from dispatch
  typedef struct packed {
    logic            valid;
    logic            cond_true;
    alb_unit_t       unit;
    logic            side_b;
    logic [6:0]      opfield;
    logic [4:0]      dst;
    logic [4:0]      src2_idx;
    logic [XLEN-1:0] src1;
    logic [4:0]      cst5;
    logic [XLEN-1:0] src2;
    logic [7:0]      src2_hi;
    logic [15:0]     signed_sixteen_bit_constant;
    logic [20:0]     branch_displacement_constant;
    logic            circ_en;
    logic [XLEN-1:0] circ_sum;
  } alb_instr_t;

  // Register write-back
  typedef struct packed {
    logic            we;
    logic            side_b;
    logic [4:0]      dst;
    logic            wide;
    logic [LLEN-1:0] data;
  } alb_wb_t;

endpackage : alb_pkg

/* File: testbench/alb_checker.sv */
// Checker for the add, logic and branch execute block
`timescale 1ns/1ns
module alb_checker (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire alb_pkg::alb_instr_t instr_a_i,
  input wire alb_pkg::alb_instr_t instr_b_i,
  input wire logic [alb_pkg::XLEN-1:0] packet_addr_i,
  input wire alb_pkg::alb_wb_t wb_a_o,
  input wire logic [alb_pkg::XLEN-1:0] program_fetch_counter_o,
  input wire logic redirect_o,
  input wire logic int_block_o
);
  import alb_pkg::*;
  alb_instr_t h;
  logic [31:0] tgt;
  function automatic logic ok(alb_instr_t x, alb_unit_t u);
    return x.valid && x.cond_true && x.unit == u;
  endfunction : ok
  always_ff @(posedge sys_clk_i) begin
    h <= rst_n_i ? instr_a_i : '0;
    if (ok(instr_a_i, ALB_UNIT_BDISP))
      tgt <= packet_addr_i + {{9{instr_a_i.branch_displacement_constant[20]}}, instr_a_i.branch_displacement_constant, 2'b00};
    else if (ok(instr_b_i, ALB_UNIT_BREG))
      tgt <= instr_b_i.src2;
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  property p_half; ok(h, ALB_UNIT_D) && h.opfield[5:0] == OP_D_HALFWORD_SCALED_ADDRESS_ADD_R && !h.circ_en
    |-> wb_a_o.data[31:0] == h.src2 + (h.src1 << 1); endproperty
  a_half: assert property (p_half) else $error("half add wrong");
  property p_word; ok(h, ALB_UNIT_D) && h.opfield[5:0] == OP_D_WORD_SCALED_ADDRESS_ADD_R && !h.circ_en
    |-> wb_a_o.data[31:0] == h.src2 + (h.src1 << 2); endproperty
  a_word: assert property (p_word) else $error("word add wrong");
  property p_kadd; ok(h, ALB_UNIT_SK)
    |-> wb_a_o.we && wb_a_o.data[31:0] == h.src2 + {{16{h.signed_sixteen_bit_constant[15]}}, h.signed_sixteen_bit_constant}; endproperty
  a_kadd: assert property (p_kadd) else $error("constant add wrong");
  property p_uadd; ok(h, ALB_UNIT_L) && h.opfield == OP_L_UNSIGNED_WIDENING_ADD_UU
    |-> wb_a_o.wide && wb_a_o.data == {8'h00, h.src1} + {8'h00, h.src2}; endproperty
  a_uadd: assert property (p_uadd) else $error("unsigned add wrong");
  property p_dual; ok(h, ALB_UNIT_SADD2) |-> wb_a_o.data[15:0] == h.src1[15:0] + h.src2[15:0]
    && wb_a_o.data[31:16] == h.src1[31:16] + h.src2[31:16]; endproperty
  a_dual: assert property (p_dual) else $error("dual add wrong");
  property p_nop; h.valid && !h.cond_true |-> !wb_a_o.we; endproperty
  a_nop: assert property (p_nop) else $error("false predicate wrote");
  property p_slot; ok(instr_a_i, ALB_UNIT_BDISP) && !instr_b_i.valid
    |=> int_block_o [*5] ##1 redirect_o && !int_block_o; endproperty
  a_slot: assert property (p_slot) else $error("delay slots wrong");
  property p_tgt; redirect_o |-> program_fetch_counter_o == tgt; endproperty
  a_tgt: assert property (p_tgt) else $error("branch target wrong");
endmodule : alb_checker
bind alb_exec alb_checker u_chk (.sys_clk_i, .rst_n_i, .instr_a_i, .instr_b_i,
  .packet_addr_i, .wb_a_o, .program_fetch_counter_o, .redirect_o, .int_block_o);

/* File: testbench/alb_disp_model.sv */
// Dispatch model presenting one execute packet for one cycle
`timescale 1ns/1ns
module alb_disp_model (
  input wire logic sys_clk_i,
  output alb_pkg::alb_instr_t instr_a_o,
  output alb_pkg::alb_instr_t instr_b_o,
  output logic [alb_pkg::XLEN-1:0] packet_addr_o
);
  import alb_pkg::*;
  initial begin
    instr_a_o = '0;
    instr_b_o = '0;
    packet_addr_o = '0;
  end
  task automatic issue(input alb_instr_t a, input alb_instr_t b);
    @(posedge sys_clk_i);
    instr_a_o <= a;
    instr_b_o <= b;
    packet_addr_o <= 32'h00001000;
    @(posedge sys_clk_i);
    a = ~a;
    b = ~b;
    a.valid = 1'b0;
    b.valid = 1'b0;
    instr_a_o <= a;
    instr_b_o <= b;
    packet_addr_o <= 32'hFFFFEFFF;
  endtask : issue
endmodule : alb_disp_model

/* File: testbench/tb_top.sv */
// Testbench for the add, logic and branch execute block
`timescale 1ns/1ns
module tb_top;
  import alb_pkg::*;
  logic sys_clk_i = 0;
  logic rst_n_i = 0;
  alb_instr_t ia, ib, i, j;
  alb_instr_t z = '0;
  logic [31:0] pa, program_fetch_counter;
  alb_wb_t wa, wb;
  logic rd, blk, ill;
  int errors = 0;
  int check_count = 0;
  always #10 sys_clk_i = ~sys_clk_i;
  alb_disp_model dm (.sys_clk_i, .instr_a_o(ia), .instr_b_o(ib), .packet_addr_o(pa));
  alb_exec uut (.sys_clk_i, .rst_n_i, .instr_a_i(ia), .instr_b_i(ib), .packet_addr_i(pa),
    .wb_a_o(wa), .wb_b_o(wb), .program_fetch_counter_o(program_fetch_counter), .redirect_o(rd),
    .int_block_o(blk), .illegal_o(ill));
  task automatic ck(input logic [40:0] got, input logic [40:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH at %0t: %h not %h", $time, got, exp);
    end
  endtask : ck
  function automatic alb_instr_t op(alb_unit_t u, logic [6:0] f);
    op = '0;
    op.valid = 1;
    op.cond_true = 1;
    op.unit = u;
    op.opfield = f;
  endfunction : op
  task automatic go(input alb_instr_t a, input alb_instr_t b, input int n);
    dm.issue(a, b);
    repeat (n) @(negedge sys_clk_i);
  endtask : go
  task automatic t_alu;
    logic [31:0] e;
    for (int k = 0; k < 6; k++) begin
      i = op(ALB_UNIT_D, 7'(OP_D_BYTE_SCALED_ADDRESS_ADD_R + 2 * k));
      i.src2 = 32'h00008000;
      i.src1 = 32'h00000013;
      i.cst5 = 5'h1F;
      go(i, z, 1);
      e = 32'h8000 + ((k[0] ? 32'h1F : 32'h13) << (k / 2));
      ck(wa.data[31:0], e);
    end
    i = op(ALB_UNIT_D, 7'(OP_D_HALFWORD_SCALED_ADDRESS_ADD_R));
    i.src2_idx = 5'h05;
    i.circ_en = 1;
    i.circ_sum = 32'h0000ABCD;
    go(i, z, 1);
    ck(wa.data[31:0], 32'h0000ABCD);
    i.src2_idx = 5'h08;
    i.src1 = 32'h00000001;
    go(i, z, 1);
    ck(wa.data[31:0], 32'h00000002);
    go(z, i, 1);
    ck({wb.we, wb.data[31:0]}, {1'b1, 32'h00000002});
    i = op(ALB_UNIT_SK, 7'h00);
    i.src2 = 32'h002137E1;
    i.signed_sixteen_bit_constant = 16'hFFFF;
    go(i, z, 1);
    ck(wa.data[31:0], 32'h002137E0);
    i.cond_true = 0;
    go(i, z, 1);
    ck(wa.we, 1'b0);
    i = op(ALB_UNIT_L, OP_L_UNSIGNED_WIDENING_ADD_UU);
    i.src1 = 32'hFFFFFFFF;
    i.src2 = 32'h00000001;
    go(i, z, 1);
    ck({wa.wide, wa.data}, {1'b1, 40'h0100000000});
    i.opfield = OP_L_UNSIGNED_WIDENING_ADD_UL;
    i.src2_hi = 8'hFE;
    go(i, z, 1);
    ck(wa.data, 40'hFF00000000);
    i = op(ALB_UNIT_SADD2, 7'h00);
    i.src1 = 32'h002137E1;
    i.src2 = 32'h039AE4B8;
    go(i, z, 1);
    ck(wa.data[31:0], 32'h03BB1C99);
    for (int k = 0; k < 4; k++) begin
      i = op(k < 2 ? ALB_UNIT_L : ALB_UNIT_S,
             k < 2 ? OP_L_AND_R - 7'(k) : 7'(OP_S_AND_R) - 7'(k - 2));
      i.src1 = 32'hFFFFFFF0;
      i.cst5 = 5'h10;
      i.src2 = 32'h32E46936;
      go(i, z, 1);
      ck(wa.data[31:0], 32'h32E46930);
    end
    $display("arithmetic and logic done");
  endtask : t_alu
  task automatic t_br;
    i = op(ALB_UNIT_BDISP, 7'h00);
    i.branch_displacement_constant = 21'h1FFFFC;
    go(i, z, 1);
    repeat (5) begin
      ck(blk, 1'b1);
      @(negedge sys_clk_i);
    end
    ck({rd, blk, program_fetch_counter}, {2'b10, 32'h00000FF0});
    i.cond_true = 0;
    j = op(ALB_UNIT_BREG, 7'h00);
    j.side_b = 1;
    j.src2 = 32'h20000000;
    go(i, j, 6);
    ck({rd, program_fetch_counter}, {1'b1, 32'h20000000});
    i.cond_true = 1;
    go(i, j, 1);
    ck(ill, 1'b1);
    j.side_b = 0;
    go(z, j, 1);
    ck(ill, 1'b1);
    repeat (5) @(negedge sys_clk_i);
    ck({rd, program_fetch_counter}, {1'b0, 32'h20000000});
    $display("branches done");
  endtask : t_br
  task automatic stop_test;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_alu();
    t_br();
    stop_test();
  end
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    errors++;
    stop_test();
  end
endmodule : tb_top
